// File: pkg/serial_comm_pkg.sv
// Purpose: constants and types of the serial comm buffer engine
// Assumes: AXI4-Lite byte address is four times the register index
// Notes: flags are plain read/write; a hardware set beats a same-cycle clear
// What this block does
// - Low group flag register holds low events; firmware reads and writes it.
// - Mask bit one unmasks matching flag in both groups; zero masks it.
// - Transmit link error is set only in PS/2 when host aborts a byte.
// - Transmit complete sets after burst length bytes sent since buffer valid set.
// - Overrun sets when receive complete sets while receive handled is clear.
// - Receive link error on framing/parity error, or PS/2 host abort.
// - Receive complete sets after burst length bytes arrived since handled set.
// - Firmware sets buffer valid; device clears it at transmit complete; zero ignored.
// - Firmware sets receive handled; device clears it after receive complete.
// - Receive burst length zero means full buffer; larger than buffer is illegal.
// - Transmit burst length zero means full buffer.
// - Read-only field shows buffer offset of most recent received byte.
// - Read-only field shows next send offset, or aborted byte offset after abort.
// - Mode change clears control registers; port data registers keep values.
// - In GPIO mode both comm pins are plain port bits.
// - Handshake control governs the engine only in PS/2 and RS-232 modes.
// - Registers at B0..BF: low flags B5, high flags B7, control B9.
package serial_comm_pkg;
  localparam logic [7:0] IDX_PORT_A = 8'hB0;
  localparam logic [7:0] IDX_PORT_B = 8'hB1;
  localparam logic [7:0] IDX_MODE = 8'hB3;
  localparam logic [7:0] IDX_LOW_FLAGS = 8'hB5;
  localparam logic [7:0] IDX_LOW_MASK = 8'hB6;
  localparam logic [7:0] IDX_HIGH_FLAGS = 8'hB7;
  localparam logic [7:0] IDX_HIGH_MASK = 8'hB8;
  localparam logic [7:0] IDX_CSR = 8'hB9;
  localparam logic [7:0] IDX_PIN_DIR = 8'hBD;
  localparam logic [7:0] IDX_BURST = 8'hBB;
  localparam logic [7:0] IDX_OFFSETS = 8'hBC;
  localparam int LO_TX_DONE = 0;
  localparam int LO_BYTE = 1;
  localparam int LO_TX_ERR = 2;
  localparam int LO_ABORT = 3;
  localparam int LO_PB6 = 6;
  localparam int LO_PB7 = 7;
  localparam int HI_RX_DONE = 0;
  localparam int HI_RX_ERR = 1;
  localparam int HI_OVERRUN = 2;
  localparam int CSR_TX_VALID = 0;
  localparam int CSR_RX_HANDLED = 4;
  localparam int MODE_USB = 0;
  localparam int MODE_PS2 = 1;
  localparam int MODE_SERIAL = 2;
  localparam logic [4:0] BUF_BYTES = 5'h08;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  typedef struct packed {
    logic tx_sent;
    logic tx_abort;
    logic rx_byte;
    logic rx_error;
    logic rx_abort;
  } link_evt_t;
  typedef struct packed {
    logic [3:0] rx_len;
    logic [3:0] tx_len;
  } burst_t;
endpackage

// File: rtl/serial_comm_buffer_engine.sv
// Purpose: register, handshake and flag logic of the non-USB comm engine
// Assumes: link events are one-cycle pulses synchronous to aclk
// Notes: bit-level line protocols live outside; this block counts and flags
`timescale 1ns/10ps
`default_nettype none
module serial_comm_buffer_engine
  import serial_comm_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire link_evt_t link_evt,
  input wire logic [1:0] eng_pin_out,
  input wire logic [1:0] eng_pin_oe,
  input wire logic [1:0] pin_in,
  output logic [1:0] pin_out,
  output logic [1:0] pin_oe,
  output logic [7:0] port_a_out,
  output logic tx_buffer_valid,
  output logic [3:0] tx_next_offset,
  output logic [3:0] rx_last_offset,
  output logic ps2_mode,
  output logic serial_mode,
  output logic irq_low,
  output logic irq_high,
  output logic irq
);

  function automatic logic [4:0] burst_bytes(input logic [3:0] field);
    burst_bytes = (field == 4'h0) ? BUF_BYTES : {1'b0, field};
  endfunction

  function automatic logic [3:0] next_offset(input logic [3:0] off);
    next_offset = (off == 4'(BUF_BYTES - 5'h01)) ? 4'h0 : off + 4'h1;
  endfunction

  logic [7:0] port_a_q, port_b_q, mode_q, low_flags_q, low_mask_q;
  logic [7:0] high_flags_q, high_mask_q, pin_dir_q;
  burst_t burst_q;
  logic tx_valid_q, rx_handled_q;
  logic [3:0] tx_off_q, rx_off_q;
  logic [4:0] tx_cnt_q, rx_cnt_q;
  logic [1:0] pin_prev_q;
  logic [7:0] wr_idx;
  logic [7:0] rd_idx;
  logic [7:0] wbyte;
  logic wr_go, wr_hit, rd_go;
  logic engine_on, mode_change;
  logic tx_sent, tx_abort, rx_byte, rx_err, rx_abort;
  logic tx_done_ev, rx_done_ev;
  logic [7:0] low_set, high_set, rd_val;
  logic rd_hit;

  // Write taken when both address and data were offered and acked together
  assign wr_go = s_axi_awready && s_axi_awvalid && s_axi_wvalid;
  assign wr_idx = s_axi_awaddr[9:2];
  assign rd_idx = s_axi_araddr[9:2];
  assign wbyte = s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
  assign rd_go = s_axi_arready && s_axi_arvalid;
  assign wr_hit = wr_go && s_axi_wstrb[0];

  always_comb begin
    case (wr_idx)
      IDX_PORT_A, IDX_PORT_B, IDX_MODE, IDX_LOW_FLAGS, IDX_LOW_MASK, IDX_HIGH_FLAGS,
      IDX_HIGH_MASK, IDX_CSR, IDX_BURST, IDX_OFFSETS, IDX_PIN_DIR: mode_change = 1'b0;
      default: mode_change = 1'b0;
    endcase
    if (wr_hit && wr_idx == IDX_MODE && wbyte != mode_q) begin
      mode_change = 1'b1;
    end
  end

  assign engine_on = mode_q[MODE_PS2] || mode_q[MODE_SERIAL];
  assign tx_sent = engine_on && tx_valid_q && link_evt.tx_sent;
  assign tx_abort = mode_q[MODE_PS2] && tx_valid_q && link_evt.tx_abort;
  assign rx_byte = engine_on && link_evt.rx_byte;
  assign rx_err = engine_on && link_evt.rx_error;
  assign rx_abort = mode_q[MODE_PS2] && link_evt.rx_abort;
  assign tx_done_ev = tx_sent && (tx_cnt_q + 5'h01 == burst_bytes(burst_q.tx_len));
  assign rx_done_ev = rx_byte && (rx_cnt_q + 5'h01 == burst_bytes(burst_q.rx_len));

  always_comb begin
    low_set = 8'h00;
    low_set[LO_TX_DONE] = tx_done_ev;
    low_set[LO_BYTE] = rx_byte;
    low_set[LO_TX_ERR] = tx_abort;
    low_set[LO_ABORT] = tx_abort || rx_abort;
    low_set[LO_PB6] = !engine_on && (pin_in[0] != pin_prev_q[0]);
    low_set[LO_PB7] = !engine_on && (pin_in[1] != pin_prev_q[1]);
    high_set = 8'h00;
    high_set[HI_RX_DONE] = rx_done_ev;
    high_set[HI_RX_ERR] = rx_err || rx_abort;
    high_set[HI_OVERRUN] = rx_done_ev && !rx_handled_q;
  end

  // AXI write channel: both ready flops pulse together for one cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (wr_idx >= IDX_PORT_A && wr_idx <= 8'hBF) ? RESP_OKAY : RESP_DECERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_comb begin
    rd_hit = 1'b1;
    case (rd_idx)
      IDX_PORT_A: rd_val = port_a_q;
      IDX_PORT_B: rd_val = {pin_in, port_b_q[5:0]};
      IDX_MODE: rd_val = mode_q;
      IDX_LOW_FLAGS: rd_val = low_flags_q;
      IDX_LOW_MASK: rd_val = low_mask_q;
      IDX_HIGH_FLAGS: rd_val = high_flags_q;
      IDX_HIGH_MASK: rd_val = high_mask_q;
      IDX_CSR: rd_val = {3'h0, rx_handled_q, 3'h0, tx_valid_q};
      IDX_BURST: rd_val = burst_q;
      IDX_OFFSETS: rd_val = {rx_off_q, tx_off_q};
      IDX_PIN_DIR: rd_val = pin_dir_q;
      default: begin
        rd_val = 8'h00;
        rd_hit = (rd_idx >= IDX_PORT_A && rd_idx <= 8'hBF);
      end
    endcase
  end

  // AXI read channel: one outstanding read, data one cycle after acceptance
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, rd_val};
        s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_DECERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Port data survive a mode change; only reset clears them
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_a_q <= REG_RESET;
      port_b_q <= REG_RESET;
      mode_q <= REG_RESET;
      // Track the pins in reset so no false edge follows its release
      pin_prev_q <= pin_in;
    end else begin
      pin_prev_q <= pin_in;
      if (wr_hit && wr_idx == IDX_PORT_A) begin
        port_a_q <= wbyte;
      end
      if (wr_hit && wr_idx == IDX_PORT_B) begin
        port_b_q <= wbyte;
      end
      if (wr_hit && wr_idx == IDX_MODE) begin
        mode_q <= wbyte;
      end
    end
  end

  // Flag registers: firmware value first, then hardware sets on top
  always_ff @(posedge aclk) begin
    if (!aresetn || mode_change) begin
      low_flags_q <= REG_RESET;
      high_flags_q <= REG_RESET;
      low_mask_q <= REG_RESET;
      high_mask_q <= REG_RESET;
      burst_q <= REG_RESET;
      pin_dir_q <= REG_RESET;
    end else begin
      low_flags_q <= ((wr_hit && wr_idx == IDX_LOW_FLAGS) ? wbyte : low_flags_q) | low_set;
      high_flags_q <= ((wr_hit && wr_idx == IDX_HIGH_FLAGS) ? wbyte : high_flags_q) | high_set;
      if (wr_hit && wr_idx == IDX_LOW_MASK) begin
        low_mask_q <= wbyte;
      end
      if (wr_hit && wr_idx == IDX_HIGH_MASK) begin
        high_mask_q <= wbyte;
      end
      if (wr_hit && wr_idx == IDX_BURST) begin
        burst_q <= wbyte;
      end
      if (wr_hit && wr_idx == IDX_PIN_DIR) begin
        pin_dir_q <= wbyte;
      end
    end
  end

  // Transmit handshake and counting
  always_ff @(posedge aclk) begin
    if (!aresetn || mode_change) begin
      tx_valid_q <= 1'b0;
      tx_cnt_q <= 5'h00;
      tx_off_q <= 4'h0;
    end else if (tx_done_ev) begin
      tx_valid_q <= 1'b0;
      tx_cnt_q <= 5'h00;
      tx_off_q <= next_offset(tx_off_q);
    end else if (wr_hit && wr_idx == IDX_CSR && wbyte[CSR_TX_VALID] && !tx_valid_q) begin
      tx_valid_q <= engine_on;
      tx_cnt_q <= 5'h00;
      tx_off_q <= 4'h0;
    end else if (tx_sent) begin
      tx_cnt_q <= tx_cnt_q + 5'h01;
      tx_off_q <= next_offset(tx_off_q);
    end
  end

  // Receive handshake; an abort holds the receive offset on the last received byte
  always_ff @(posedge aclk) begin
    if (!aresetn || mode_change) begin
      rx_handled_q <= 1'b0;
      rx_cnt_q <= 5'h00;
      rx_off_q <= 4'h0;
    end else begin
      if (rx_byte) begin
        rx_off_q <= (rx_cnt_q == 5'h00) ? 4'h0 : next_offset(rx_off_q);
        rx_cnt_q <= rx_done_ev ? 5'h00 : rx_cnt_q + 5'h01;
      end
      if (rx_done_ev) begin
        rx_handled_q <= 1'b0;
      end else if (wr_hit && wr_idx == IDX_CSR && wbyte[CSR_RX_HANDLED] && engine_on) begin
        rx_handled_q <= 1'b1;
        rx_cnt_q <= 5'h00;
      end
    end
  end

  // Outputs straight from flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_low <= 1'b0;
      irq_high <= 1'b0;
      irq <= 1'b0;
      pin_out <= 2'h0;
      pin_oe <= 2'h0;
      port_a_out <= 8'h00;
      tx_buffer_valid <= 1'b0;
      tx_next_offset <= 4'h0;
      rx_last_offset <= 4'h0;
      ps2_mode <= 1'b0;
      serial_mode <= 1'b0;
    end else begin
      irq_low <= |(low_flags_q & low_mask_q);
      irq_high <= |(high_flags_q & high_mask_q);
      irq <= |(low_flags_q & low_mask_q) || |(high_flags_q & high_mask_q);
      pin_out <= engine_on ? eng_pin_out : port_b_q[7:6];
      pin_oe <= engine_on ? eng_pin_oe : pin_dir_q[7:6];
      port_a_out <= port_a_q;
      tx_buffer_valid <= tx_valid_q;
      tx_next_offset <= tx_off_q;
      rx_last_offset <= rx_off_q;
      ps2_mode <= mode_q[MODE_PS2];
      serial_mode <= mode_q[MODE_SERIAL];
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_tx_done_clears: assert property (tx_done_ev && !mode_change |=> !tx_valid_q && low_flags_q[LO_TX_DONE])
    else $error("tx complete did not clear buffer valid");
  a_tx_zero_ignored: assert property (tx_valid_q && !tx_done_ev && !mode_change |=> tx_valid_q)
    else $error("buffer valid dropped without complete");
  a_overrun_set: assert property (rx_done_ev && !rx_handled_q && !mode_change |=> high_flags_q[HI_OVERRUN])
    else $error("overrun not flagged");
  a_rx_err_set: assert property ((rx_err || rx_abort) && !mode_change |=> high_flags_q[HI_RX_ERR])
    else $error("receive error not flagged");
  a_rx_handled_drop: assert property (rx_done_ev && !mode_change |=> !rx_handled_q)
    else $error("receive handled not cleared");
  a_irq_low_level: assert property (|(low_flags_q & low_mask_q) |=> irq_low)
    else $error("low interrupt missing");
  a_irq_masked: assert property (!(|(high_flags_q & high_mask_q)) |=> !irq_high)
    else $error("masked high interrupt raised");
  a_flag_set_wins: assert property (low_set[LO_BYTE] && !mode_change |=> low_flags_q[LO_BYTE])
    else $error("event lost against clear");
  a_mode_clears: assert property (mode_change |=> low_flags_q == 8'h00 && !tx_valid_q ##1 !irq_low)
    else $error("mode change left control state");
  a_tx_err_ps2: assert property (!mode_q[MODE_PS2] |=> !low_set[LO_TX_ERR])
    else $error("tx link error outside PS/2");
  a_gpio_pins: assert property (!engine_on && !mode_change |=>
    pin_out == $past(port_b_q[7:6]) && pin_oe == $past(pin_dir_q[7:6]))
    else $error("pin not in GPIO use");
  c_tx_burst: cover property (tx_done_ev);
  c_overrun: cover property (high_set[HI_OVERRUN]);
  c_clear_collide: cover property (wr_hit && wr_idx == IDX_LOW_FLAGS && low_set[LO_BYTE]);
  c_mode_change: cover property (mode_change ##1 tx_valid_q == 1'b0);

endmodule
`default_nettype wire

// File: tb/link_host_model.sv
// Purpose: far-side link host model that feeds byte events and drives the comm pins
// Assumes: events are one-cycle pulses on aclk, changed just after a rising edge
// Notes: gap 0 gives back-to-back pulses, a larger gap models a slow host
`timescale 1ns/10ps
`default_nettype none
module link_host_model
  import serial_comm_pkg::*;
(
  input wire logic aclk,
  output link_evt_t link_evt,
  output logic [1:0] eng_pin_out,
  output logic [1:0] eng_pin_oe
);
  initial begin
    link_evt = '0;
    eng_pin_out = 2'h3;
    eng_pin_oe = 2'h0;
  end
  // Aborts are only sent when a scenario asks for them
  task automatic send(input link_evt_t kind, input int n, input int gap);
    @(posedge aclk);
    for (int i = 0; i < n; i++) begin
      link_evt <= kind;
      @(posedge aclk);
      if (gap > 0) begin
        link_evt <= '0;
        repeat (gap) @(posedge aclk);
      end
    end
    link_evt <= '0;
  endtask
  task automatic set_pins(input logic [1:0] val, input logic [1:0] oe);
    @(posedge aclk);
    eng_pin_out <= val;
    eng_pin_oe <= oe;
  endtask
endmodule
`default_nettype wire

// File: tb/testbench.sv
// Purpose: self-checking bench for the serial comm buffer engine
// Assumes: AXI4-Lite byte address is four times the register index
// Notes: reads queue their expected word, a monitor compares at each read answer
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import serial_comm_pkg::*;
  localparam link_evt_t EV_TX = 5'h10;
  localparam link_evt_t EV_TXAB = 5'h08;
  localparam link_evt_t EV_RX = 5'h04;
  localparam link_evt_t EV_RXERR = 5'h02;
  localparam link_evt_t EV_RXAB = 5'h01;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [3:0] wstrb, tx_off, rx_off;
  logic [1:0] bresp, rresp, eng_out, eng_oe, pin_in, pin_out, pin_oe;
  logic [7:0] port_a_out;
  logic txv, ps2m, serm, irq_low, irq_high, irq;
  link_evt_t evt;
  logic [33:0] notes[$];
  int fail_count = 0;
  int n_compared = 0;
  int cycles = 0;
  serial_comm_buffer_engine uut(.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .link_evt(evt), .eng_pin_out(eng_out),
    .eng_pin_oe(eng_oe), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .port_a_out(port_a_out),
    .tx_buffer_valid(txv), .tx_next_offset(tx_off), .rx_last_offset(rx_off), .ps2_mode(ps2m),
    .serial_mode(serm), .irq_low(irq_low), .irq_high(irq_high), .irq(irq));
  link_host_model host(.aclk(aclk), .link_evt(evt), .eng_pin_out(eng_out), .eng_pin_oe(eng_oe));
  // Pull-up lines: low only where someone drives a zero
  assign pin_in = ~(pin_oe & ~pin_out);
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    if (fail_count == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] resp = RESP_OKAY);
    @(posedge aclk);
    awaddr <= {22'h0, idx, 2'h0};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    chk(bresp, resp);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp, input logic [1:0] resp = RESP_OKAY);
    notes.push_back({resp, 24'h0, exp});
    @(posedge aclk);
    araddr <= {22'h0, idx, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask
  always @(posedge aclk) begin
    if (rvalid === 1'b1 && rready === 1'b1) begin
      if (notes.size() == 0) chk({rresp, rdata}, 34'h3FFFFFFFF);
      else chk({rresp, rdata}, notes.pop_front());
    end
  end
  // Ceiling well above the few hundred cycles the sequence needs
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      report_and_stop();
    end
  end
  initial begin
    logic [7:0] pa;
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, wdata, araddr} = '0;
    wstrb = 4'hF;
    void'($urandom(17904));
    pa = 8'($urandom());
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd(IDX_CSR, 8'h00);
    rd(8'h00, 8'h00, RESP_DECERR);
    wr(8'h00, 8'h55, RESP_DECERR);
    wr(IDX_PORT_A, pa);
    wr(IDX_MODE, 8'h02);
    wr(IDX_LOW_MASK, 8'h0F);
    wr(IDX_HIGH_MASK, 8'h07);
    wr(IDX_BURST, 8'h30);
    rd(IDX_HIGH_MASK, 8'h07);
    wr(IDX_CSR, 8'h01);
    wr(IDX_CSR, 8'h00);
    rd(IDX_CSR, 8'h01);
    host.send(EV_TX, 7, 0);
    rd(IDX_LOW_FLAGS, 8'h00);
    chk(tx_off, 4'h7);
    host.send(EV_TX, 1, 2);
    rd(IDX_LOW_FLAGS, 8'h01);
    rd(IDX_CSR, 8'h00);
    chk({irq_low, irq, txv}, 3'b110);
    wr(IDX_LOW_MASK, 8'h00);
    repeat (3) @(posedge aclk);
    chk({irq_low, irq}, 2'b00);
    wr(IDX_LOW_FLAGS, 8'h04);
    rd(IDX_LOW_FLAGS, 8'h04);
    wr(IDX_LOW_FLAGS, 8'h00);
    rd(IDX_LOW_FLAGS, 8'h00);
    host.send(EV_RX, 3, $urandom_range(0, 2));
    rd(IDX_HIGH_FLAGS, 8'h05);
    chk({rx_off, irq_high, irq}, 6'h0B);
    wr(IDX_HIGH_FLAGS, 8'h00);
    wr(IDX_CSR, 8'h10);
    wr(IDX_CSR, 8'h00);
    rd(IDX_CSR, 8'h10);
    host.send(EV_RX, 3, 0);
    rd(IDX_HIGH_FLAGS, 8'h01);
    rd(IDX_CSR, 8'h00);
    wr(IDX_HIGH_FLAGS, 8'h00);
    wr(IDX_LOW_FLAGS, 8'h00);
    host.send(EV_RXERR, 1, 0);
    rd(IDX_HIGH_FLAGS, 8'h02);
    wr(IDX_HIGH_FLAGS, 8'h00);
    host.send(EV_RXAB, 1, 0);
    rd(IDX_HIGH_FLAGS, 8'h02);
    rd(IDX_LOW_FLAGS, 8'h08);
    wr(IDX_LOW_FLAGS, 8'h00);
    wr(IDX_BURST, 8'h34);
    wr(IDX_CSR, 8'h01);
    host.send(EV_TX, 2, 1);
    host.send(EV_TXAB, 1, 0);
    rd(IDX_LOW_FLAGS, 8'h0C);
    chk({tx_off, txv}, 5'h05);
    host.set_pins(2'b10, 2'b01);
    repeat (3) @(posedge aclk);
    chk({pin_out, pin_oe, ps2m}, 5'b10011);
    wr(IDX_MODE, 8'h04);
    rd(IDX_CSR, 8'h00);
    rd(IDX_BURST, 8'h00);
    rd(IDX_LOW_FLAGS, 8'h00);
    rd(IDX_LOW_MASK, 8'h00);
    rd(IDX_PORT_A, pa);
    chk({port_a_out, serm}, {pa, 1'b1});
    wr(IDX_BURST, 8'h01);
    wr(IDX_CSR, 8'h01);
    host.send(EV_TXAB, 1, 0);
    rd(IDX_LOW_FLAGS, 8'h00);
    host.send(EV_TX, 1, 0);
    rd(IDX_LOW_FLAGS, 8'h01);
    wr(IDX_MODE, 8'h00);
    wr(IDX_PORT_B, 8'h40);
    wr(IDX_PIN_DIR, 8'hC0);
    repeat (3) @(posedge aclk);
    chk({pin_out, pin_oe}, 4'b0111);
    rd(IDX_PORT_B, 8'h40);
    wr(IDX_CSR, 8'h01);
    rd(IDX_CSR, 8'h00);
    repeat (4) @(posedge aclk);
    report_and_stop();
  end
endmodule
`default_nettype wire
